// >>> hdl/psr_fifo.sv
// first-in first-out queue of stage events, width and depth parameters
// assumes synchronous use on one clock, active-low asynchronous reset
`timescale 1ns/1ps
module psr_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    psr_stream_if.snk wr,
    psr_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic full;
    logic empty;
    logic do_wr;
    logic do_rd;

    // full when pointers differ only in the wrap bit
    assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                  (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rd_ptr_reg[AW-1:0]];
    assign do_wr = wr.valid && !full;
    assign do_rd = rd.ready && !empty;

    // storage, no reset needed
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr_reg[AW-1:0]] <= wr.data;
        end
    end

    // write pointer
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr_reg <= '0;
        end else if (do_wr) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    // read pointer
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_ptr_reg <= '0;
        end else if (do_rd) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule : psr_fifo

// >>> hdl/psr_pkg.sv
// types and helpers shared by the shift register and its bench
// assumes psr_regs.svh is on the include path
`include "psr_regs.svh"
package psr_pkg;
    typedef logic [`PSR_STAGES-1:0] psr_stage_type;
    typedef logic [`PSR_EVT_W-1:0] psr_evt_type;
    // operating mode, one-hot
    typedef enum logic [1:0] {
        PSR_MODE_LOAD = 2'h1,
        PSR_MODE_SHIFT = 2'h2
    } psr_mode_type;

    // move every stage one place toward the output, new bit in stage 0
    function automatic psr_stage_type psr_shift_in(
        input psr_stage_type stages,
        input logic ser
    );
        psr_shift_in = {stages[`PSR_STAGES-2:0], ser};
    endfunction : psr_shift_in
endpackage : psr_pkg

// >>> hdl/psr_regs.svh
// constants of the parallel-load shift register: widths, depths, resets
// assumes inclusion by bare name from the package and design modules
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH

`define PSR_STAGES 8
`define PSR_EVT_W 9
`define PSR_KIND_BIT 8
`define PSR_FIFO_DEPTH 32
`define PSR_PIN_RST 1'h1
`define PSR_CNT_W 4
`define PSR_CNT_RST 4'h0
`define PSR_CNT_FULL 4'h8
`define PSR_OE_RST 1'h0

`endif

// >>> hdl/psr_stream_if.sv
// valid/ready carrier for stage events between the pin decoder and engine
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface psr_stream_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : psr_stream_if

// >>> hdl/psr_top.sv
// eight-stage parallel-load / serial-in shift register, open-drain outputs
// assumes all pin inputs synchronous to CORE_CLK_I; pull-ups sit outside
`timescale 1ns/1ps
`include "psr_regs.svh"

// Overview of operation
// RULE1 - eight stages, parallel or serial fill
// RULE2 - two modes: load and shift
// RULE3 - load low copies parallel inputs, clocks ignored
// RULE4 - during load output shows last parallel input
// RULE5 - no edge in shift mode holds stages
// RULE6 - edge shifts stages, serial into first
// RULE7 - last stage value dropped on shift
// RULE8 - outputs always reflect last stage; both pull-low enables are released while RSTN_I is low
// RULE9 - inhibit high blocks clock edges
// RULE10 - clock and inhibit interchangeable
// RULE11 - shift toward output, last parallel first
// RULE12 - outputs only pull low, else released
// RULE13 - no reset of stages, unknown at start
// RULE14 - controller loads, then clocks seven times
// RULE15 - pull-low enable asserted for logic low
module psr_top
    import psr_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic SHIFT_NOT_LOAD_I,
    input wire logic SHIFT_CLK_I,
    input wire logic CLOCK_INHIBIT_I,
    input wire logic SERIAL_I,
    input wire logic [`PSR_STAGES-1:0] PAR_I,
    input wire logic FREEZE_I,
    output logic SER_Q_O,
    output logic SER_Q_OE_O,
    output logic SER_QN_O,
    output logic SER_QN_OE_O,
    output logic DATA_VALID_O,
    output logic EVT_READY_O
);
    psr_mode_type mode_reg;
    psr_mode_type mode_next;
    logic clk_prev_reg;
    logic inh_prev_reg;
    psr_stage_type par_prev_reg;
    logic clk_rise;
    logic inh_rise;
    logic shift_evt;
    logic load_evt;
    psr_stage_type stage_reg;
    psr_stage_type stage_next;
    logic [`PSR_CNT_W-1:0] cnt_reg;
    logic [`PSR_CNT_W-1:0] cnt_next;
    logic q_oe_reg;
    logic qn_oe_reg;
    logic valid_reg;
    logic ready_reg;
    logic pop;
    logic pop_load;

    psr_stream_if #(.W(`PSR_EVT_W)) ev_in ();
    psr_stream_if #(.W(`PSR_EVT_W)) ev_out ();

    // mode follows the shift-not-load pin
    assign mode_next = SHIFT_NOT_LOAD_I ? PSR_MODE_SHIFT : PSR_MODE_LOAD;

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mode_reg <= PSR_MODE_SHIFT;
        end else begin
            mode_reg <= mode_next; // RULE2
        end
    end

    // previous pin levels for edge detection; reset high so no false edge
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            clk_prev_reg <= `PSR_PIN_RST;
            inh_prev_reg <= `PSR_PIN_RST;
        end else begin
            clk_prev_reg <= SHIFT_CLK_I;
            inh_prev_reg <= CLOCK_INHIBIT_I;
        end
    end

    // last parallel word seen, so repeated loads of one word queue once
    always_ff @(posedge CORE_CLK_I) begin
        par_prev_reg <= PAR_I;
    end

    // rising edge on either clock pin; the other pin being low is checked in shift_evt
    assign clk_rise = SHIFT_CLK_I && !clk_prev_reg;
    assign inh_rise = CLOCK_INHIBIT_I && !inh_prev_reg;

    // edges only count in shift mode
    always_comb begin
        shift_evt = 1'b0;
        case (mode_next)
            PSR_MODE_SHIFT: begin
                shift_evt = (clk_rise && !CLOCK_INHIBIT_I) || // RULE9
                            (inh_rise && !SHIFT_CLK_I); // RULE10
            end
            PSR_MODE_LOAD: begin
                shift_evt = 1'b0; // RULE3
            end
            default: begin
                shift_evt = 1'b0;
            end
        endcase
    end

    // load queued on entering load mode or when the parallel word changes
    assign load_evt = (mode_next == PSR_MODE_LOAD) &&
                      ((mode_reg != PSR_MODE_LOAD) ||
                       (PAR_I != par_prev_reg)); // RULE3

    // event word: kind bit, then parallel word or serial bit
    assign ev_in.valid = load_evt || shift_evt;
    assign ev_in.data = load_evt ? {1'b1, PAR_I} :
                        {1'b0, {(`PSR_STAGES-1){1'b0}}, SERIAL_I};

    // queue between pin decoder and stage engine
    psr_fifo #(
        .W(`PSR_EVT_W),
        .DEPTH(`PSR_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .wr(ev_in),
        .rd(ev_out)
    );

    // engine drains one event per cycle unless frozen
    assign ev_out.ready = !FREEZE_I;
    assign pop = ev_out.valid && ev_out.ready;
    assign pop_load = pop && ev_out.data[`PSR_KIND_BIT];

    // next stage contents
    always_comb begin
        stage_next = stage_reg; // RULE5
        if (pop_load) begin
            stage_next = ev_out.data[`PSR_STAGES-1:0]; // RULE3
        end else if (pop) begin
            // last stage falls off the end and is not kept
            stage_next = psr_shift_in(stage_reg, ev_out.data[0]); // RULE6
        end
    end

    // the stages themselves carry no reset
    always_ff @(posedge CORE_CLK_I) begin
        stage_reg <= stage_next; // RULE1 RULE7 RULE11 RULE13
    end

    // shifts since start; data valid after a load or eight shifts
    always_comb begin
        cnt_next = cnt_reg;
        if (pop_load) begin
            cnt_next = `PSR_CNT_FULL;
        end else if (pop && cnt_reg != `PSR_CNT_FULL) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cnt_reg <= `PSR_CNT_RST;
            valid_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            valid_reg <= (cnt_next == `PSR_CNT_FULL); // RULE13
        end
    end

    // open-drain drives: enable pulls low, released in reset, then follows last stage even before data valid
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            q_oe_reg <= `PSR_OE_RST;
            qn_oe_reg <= `PSR_OE_RST;
        end else begin
            q_oe_reg <= !stage_next[`PSR_STAGES-1]; // RULE8 RULE15
            qn_oe_reg <= stage_next[`PSR_STAGES-1]; // RULE12 RULE4
        end
    end

    // room in the event queue, seen by the controller
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= ev_in.ready;
        end
    end

    // driven level of an open-drain pin is always low
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            SER_Q_O <= 1'b0;
            SER_QN_O <= 1'b0;
        end else begin
            SER_Q_O <= 1'b0; // RULE12
            SER_QN_O <= 1'b0; // RULE12
        end
    end

    assign SER_Q_OE_O = q_oe_reg;
    assign SER_QN_OE_O = qn_oe_reg;
    assign DATA_VALID_O = valid_reg;
    assign EVT_READY_O = ready_reg;

    // checks of the stage engine and pin decoder
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    AST_LOAD_TAKES_PAR: assert property ( // RULE3
        pop_load |=> stage_reg == $past(ev_out.data[`PSR_STAGES-1:0]))
        else $error("load did not copy parallel word");

    AST_SHIFT_MOVES: assert property ( // RULE6
        valid_reg && pop && !ev_out.data[`PSR_KIND_BIT] |=>
        stage_reg == {$past(stage_reg[`PSR_STAGES-2:0]),
                      $past(ev_out.data[0])})
        else $error("shift did not move stages");

    AST_HOLD_NO_EDGE: assert property ( // RULE5
        valid_reg && !pop |=> stage_reg == $past(stage_reg))
        else $error("stages changed without event");

    AST_H_ON_OUTPUT: assert property ( // RULE4
        pop_load |=> q_oe_reg == !$past(ev_out.data[`PSR_STAGES-1]))
        else $error("output not following last parallel bit");

    AST_OUT_TRACKS: assert property ( // RULE8
        valid_reg |-> q_oe_reg == !stage_reg[`PSR_STAGES-1])
        else $error("true output not tracking last stage");

    AST_COMPLEMENT: assert property ( // RULE12
        valid_reg |-> q_oe_reg != qn_oe_reg && !SER_Q_O && !SER_QN_O)
        else $error("outputs not complementary open-drain");

    AST_INHIBIT: assert property ( // RULE9
        CLOCK_INHIBIT_I && inh_prev_reg |-> !shift_evt)
        else $error("shift while clock inhibit high");

    AST_SYMMETRIC: assert property ( // RULE10
        $past(RSTN_I) && SHIFT_NOT_LOAD_I && $rose(CLOCK_INHIBIT_I) &&
        !SHIFT_CLK_I && ev_in.ready |->
        ev_in.valid && !ev_in.data[`PSR_KIND_BIT])
        else $error("inhibit edge did not shift");

    AST_LOAD_MODE: assert property ( // RULE2
        !SHIFT_NOT_LOAD_I |-> !shift_evt)
        else $error("shift seen in load mode");

    AST_VALID_AFTER_LOAD: assert property ( // RULE13
        pop_load |=> valid_reg ##1 valid_reg)
        else $error("data not valid after load");

    AST_EIGHT_SHIFTS: assert property ( // RULE13
        !valid_reg && pop && cnt_reg == 4'h7 |=> valid_reg)
        else $error("not valid after eight shifts");

    // pin events reach the queue; entry and clock-edge checks skipped in the cycle after release
    AST_ENTRY_LOAD_QUEUED: assert property ( // RULE3
        $past(RSTN_I) && !SHIFT_NOT_LOAD_I && $past(SHIFT_NOT_LOAD_I) &&
        ev_in.ready |-> ev_in.valid && ev_in.data == {1'b1, PAR_I})
        else $error("entry into load mode not queued");
    AST_PAR_CHANGE_QUEUED: assert property ( // RULE3
        !SHIFT_NOT_LOAD_I && PAR_I != $past(PAR_I) && ev_in.ready |->
        ev_in.valid && ev_in.data[`PSR_KIND_BIT])
        else $error("parallel change in load mode not queued");
    AST_CLK_EDGE_SHIFTS: assert property ( // RULE10
        $past(RSTN_I) && SHIFT_NOT_LOAD_I && $rose(SHIFT_CLK_I) &&
        !CLOCK_INHIBIT_I && ev_in.ready |->
        ev_in.valid && !ev_in.data[`PSR_KIND_BIT] &&
        ev_in.data[0] == SERIAL_I)
        else $error("clock edge did not queue a shift");

    // first stage is defined even before the data is valid
    AST_SER_CAPTURED: assert property ( // RULE6
        pop && !ev_out.data[`PSR_KIND_BIT] |=>
        stage_reg[0] == $past(ev_out.data[0]))
        else $error("serial bit not taken into first stage");

    // a frozen engine leaves the stages alone
    AST_FROZEN_NO_POP: assert property ( // RULE5
        FREEZE_I |-> !pop)
        else $error("event applied while frozen");
    AST_FROZEN_HOLD: assert property ( // RULE5
        valid_reg && FREEZE_I |=> $stable(stage_reg))
        else $error("stages moved while frozen");

    // pin-level view of the open-drain outputs
    AST_PIN_LOAD_OUT: assert property ( // RULE4
        pop_load |=> SER_Q_OE_O == !$past(ev_out.data[`PSR_STAGES-1]) &&
        SER_QN_OE_O == $past(ev_out.data[`PSR_STAGES-1]))
        else $error("pins not showing last parallel bit");
    AST_DRIVE_LOW: assert property ( // RULE12
        !SER_Q_O && !SER_QN_O)
        else $error("open-drain pin driven high");

    // shift count and data valid flag
    AST_CNT_SATURATES: assert property ( // RULE13
        cnt_reg == `PSR_CNT_FULL |=> cnt_reg == `PSR_CNT_FULL)
        else $error("shift count left its end value");
    AST_VALID_STAYS: assert property ( // RULE13
        valid_reg |=> valid_reg)
        else $error("data valid dropped without reset");
    AST_VALID_BEFORE_EIGHT: assert property ( // RULE13
        !valid_reg && pop && !pop_load && cnt_reg < 4'h7 |=> !valid_reg)
        else $error("data valid before eight shifts");

    COV_LOAD: cover property (pop_load ##1 valid_reg);
    COV_SHIFT_CLK: cover property (clk_rise && shift_evt);
    COV_SHIFT_INH: cover property (inh_rise && shift_evt);
    COV_QUEUE_FULL: cover property (!ev_in.ready && FREEZE_I);
    COV_RELOAD: cover property (pop_load ##1 pop_load);
endmodule : psr_top

// >>> tb/psr_ctrl_model.sv
// controller model on the far side: drives load, clock, inhibit, serial
// and parallel pins, samples the resolved true output pin
// assumes the core clock of the bench; all pins change just after edges
`timescale 1ns/1ps
module psr_ctrl_model (
    input wire logic clk_i,
    input wire logic q_pin_i,
    output logic shift_not_load_o,
    output logic shift_clk_o,
    output logic clock_inhibit_o,
    output logic serial_o,
    output logic [7:0] par_o
);
    // idle levels: shift mode, both clock pins low
    initial begin
        shift_not_load_o = 1'h1;
        shift_clk_o = 1'h0;
        clock_inhibit_o = 1'h0;
        serial_o = 1'h0;
        par_o = 8'h00;
    end

    // one load pulse, then parallel lines move off the loaded value
    task automatic load(input logic [7:0] d);
        @(posedge clk_i);
        shift_not_load_o <= 1'h0;
        par_o <= d;
        @(posedge clk_i);
        shift_not_load_o <= 1'h1;
        @(posedge clk_i);
        par_o <= ~d;
        #1;
    endtask : load

    // load held low while the parallel word changes from d to e
    task automatic load_twice(input logic [7:0] d, input logic [7:0] e);
        @(posedge clk_i);
        shift_not_load_o <= 1'h0;
        par_o <= d;
        @(posedge clk_i);
        par_o <= e;
        @(posedge clk_i);
        shift_not_load_o <= 1'h1;
        @(posedge clk_i);
        #1;
    endtask : load_twice

    // rise pins in {inhibit, clock}, then leave them at rest levels
    task automatic pulse(input logic [1:0] rise, input logic [1:0] rest,
                         input logic s);
        @(posedge clk_i);
        serial_o <= s;
        {clock_inhibit_o, shift_clk_o} <= rise;
        @(posedge clk_i);
        {clock_inhibit_o, shift_clk_o} <= rest;
        serial_o <= ~s; // bit no longer held after its edge
        @(posedge clk_i);
        #1;
    endtask : pulse

    // load, sample, then fifteen shifts sampling after each
    task automatic read_word(input logic sel, input logic [7:0] d,
                             input logic [7:0] s, output logic [15:0] w);
        load(d);
        w[15] = q_pin_i;
        for (int i = 1; i < 16; i++) begin
            pulse(sel ? 2'h2 : 2'h1, 2'h0, (i <= 8) ? s[8-i] : 1'h0);
            w[15-i] = q_pin_i;
        end
    endtask : read_word
endmodule : psr_ctrl_model

// >>> tb/tb_top.sv
// self-checking bench of the shift register with its controller model
// assumes pull-ups on both open-drain outputs, resolved here
`timescale 1ns/1ps
`include "psr_regs.svh"
module tb_top;
    import psr_pkg::*;
    typedef struct {
        logic [7:0] par;
        logic [7:0] ser;
        logic sel;
        logic [15:0] exp;
    } psr_row_type;
    logic clk, rstn, freeze, snl, sclk, inh, ser;
    logic [7:0] par;
    logic q, q_oe, qn, qn_oe, valid, evt_ready, q_pin, qn_pin;
    logic [15:0] w;
    int fail_count = 0;
    int checks_done = 0;
    psr_row_type rows [4] = '{
        '{8'hA5, 8'h3C, 1'h0, 16'hA53C}, '{8'h5A, 8'hC3, 1'h1, 16'h5AC3},
        '{8'hFF, 8'h00, 1'h0, 16'hFF00}, '{8'h01, 8'h80, 1'h1, 16'h0180}};

    // pull-ups: a pin reads low only while its pull-low enable is high
    assign q_pin = q_oe ? q : 1'h1;
    assign qn_pin = qn_oe ? qn : 1'h1;

    // core clock, 8 ns period
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    psr_top i_dut (.CORE_CLK_I(clk), .RSTN_I(rstn),
        .SHIFT_NOT_LOAD_I(snl), .SHIFT_CLK_I(sclk),
        .CLOCK_INHIBIT_I(inh), .SERIAL_I(ser), .PAR_I(par),
        .FREEZE_I(freeze), .SER_Q_O(q), .SER_Q_OE_O(q_oe),
        .SER_QN_O(qn), .SER_QN_OE_O(qn_oe), .DATA_VALID_O(valid),
        .EVT_READY_O(evt_ready));

    psr_ctrl_model i_ctrl (.clk_i(clk), .q_pin_i(q_pin),
        .shift_not_load_o(snl), .shift_clk_o(sclk),
        .clock_inhibit_o(inh), .serial_o(ser), .par_o(par));

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : check

    // print counts and verdict, end the run
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // watchdog
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end

    // main sequence
    initial begin
        rstn = 1'h0;
        freeze = 1'h0;
        repeat (8) @(posedge clk);
        #1;
        check({q_oe, qn_oe, valid}, 16'h0, "outputs in reset");
        @(posedge clk);
        rstn <= 1'h1;
        // table: load, read parallel bits then serial bits, both pins
        foreach (rows[i]) begin
            i_ctrl.read_word(rows[i].sel, rows[i].par, rows[i].ser, w);
            check(w, rows[i].exp, "serial stream");
            check(qn_pin, !q_pin, "inverted pin");
            check({q, qn, valid}, 16'h1, "drive levels");
        end
        // load shows last parallel input on both pins
        i_ctrl.load(8'hA0);
        check({q_pin, qn_pin}, 16'h2, "load high");
        // both pins rising together, then clock under inhibit: no shift
        i_ctrl.pulse(2'h3, 2'h2, 1'h0);
        check({q_oe, qn_oe}, 16'h1, "both rise");
        i_ctrl.pulse(2'h3, 2'h2, 1'h0);
        check({q_oe, qn_oe}, 16'h1, "inhibited");
        i_ctrl.pulse(2'h0, 2'h0, 1'h0);
        check({q_oe, qn_oe}, 16'h1, "inhibit fall");
        i_ctrl.pulse(2'h1, 2'h0, 1'h0);
        check({q_pin, qn_pin}, 16'h1, "shift after inhibit");
        // frozen queue: load plus 31 shifts fit, later pulses dropped
        @(posedge clk);
        freeze <= 1'h1;
        i_ctrl.load(8'h00);
        for (int k = 1; k <= 40; k++) begin
            i_ctrl.pulse(2'h1, 2'h0, k == 24);
        end
        check(evt_ready, 16'h0, "queue full");
        @(posedge clk);
        freeze <= 1'h0;
        repeat (40) @(posedge clk);
        #1;
        check(evt_ready, 16'h1, "queue drained");
        check({q_pin, qn_pin}, 16'h2, "bit of shift 24");
        // reset in mid-run, then data valid only after eight shifts
        @(posedge clk);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        #1;
        check({q_oe, qn_oe, valid, evt_ready}, 16'h0, "in reset");
        @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        #1;
        check({valid, evt_ready}, 16'h1, "after release");
        for (int k = 0; k < 7; k++) begin
            i_ctrl.pulse(2'h1, 2'h0, k == 0);
        end
        check(valid, 16'h0, "seven shifts");
        i_ctrl.pulse(2'h2, 2'h0, 1'h0);
        check({valid, q_pin, qn_pin}, 16'h6, "eight shifts");
        // word changed while load is held low is taken again
        i_ctrl.load_twice(8'h00, 8'h80);
        check({q_pin, qn_pin}, 16'h2, "reload in load mode");
        report_and_stop();
    end
endmodule : tb_top
